// >>> core/presence_responder.sv
// Detects a host reset pulse on one line and answers with a presence pulse
`timescale 1ns/1ps
`default_nettype none
module presence_responder
   import token_link_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic line_in,
   input  wire logic enable,
   output var  logic pull_low
);
   pres_state_t state_reg;
   logic [11:0] cnt_reg;

   // ----------------------------------------------------------------
   // Reset detection and presence pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= PR_IDLE;
         cnt_reg   <= 12'h000;
      end else if (!enable) begin
         state_reg <= PR_IDLE;
         cnt_reg   <= 12'h000;
      end else begin
         case (state_reg)
            PR_IDLE: begin
               // The first low sample already counts toward the minimum
               cnt_reg <= 12'h001;
               if (!line_in)
                  state_reg <= PR_LOW;
            end
            PR_LOW: begin
               if (line_in) begin
                  cnt_reg   <= 12'h000;
                  state_reg <= (cnt_reg >= RST_LOW_MIN_CYC) ? PR_WAIT : PR_IDLE;
               end else if (cnt_reg != 12'hFFF) begin
                  cnt_reg <= cnt_reg + 12'h001;
               end
            end
            PR_WAIT: begin
               cnt_reg <= cnt_reg + 12'h001;
               if (cnt_reg == PRES_DELAY_CYC - 12'h001) begin
                  cnt_reg   <= 12'h000;
                  state_reg <= PR_PULSE;
               end
            end
            PR_PULSE: begin
               cnt_reg <= cnt_reg + 12'h001;
               if (cnt_reg == PRES_WIDTH_CYC - 12'h001) begin
                  cnt_reg   <= 12'h000;
                  state_reg <= PR_IDLE;
               end
            end
            default: begin
               state_reg <= PR_IDLE;
               cnt_reg   <= 12'h000;
            end
         endcase
      end
   end

   // Pulse covers the host's presence-sample window
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         pull_low <= 1'b0;
      else
         pull_low <= enable && (state_reg == PR_WAIT) &&
                     (cnt_reg == PRES_DELAY_CYC - 12'h001) ||
                     enable && (state_reg == PR_PULSE) &&
                     (cnt_reg != PRES_WIDTH_CYC - 12'h001);
   end
endmodule
`default_nettype wire

// >>> core/token_link_pkg.sv
// Constants and carrier types for the dual-port token pin control
package token_link_pkg;

   // ----------------------------------------------------------------
   // Clock and internal time base
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned OSC_HZ         = 30_000;
   localparam int unsigned TIMER_HZ       = 10_000;
   localparam int unsigned OSC_DIV        = CLK_HZ / OSC_HZ;
   localparam int unsigned TIMER_DIV      = OSC_HZ / TIMER_HZ;
   localparam logic [3:0]  TIMER_TIMEOUT  = 4'h1;

   // ----------------------------------------------------------------
   // Power-up times
   // ----------------------------------------------------------------
   localparam int unsigned WARMUP_US       = 5000;
   localparam int unsigned WARMUP_CYC      = WARMUP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CHG_SENSE_US    = 1500;
   localparam int unsigned CHG_SENSE_CYC   = CHG_SENSE_US * (CLK_HZ / 1_000_000);

   // ----------------------------------------------------------------
   // Line reset and presence timing
   // ----------------------------------------------------------------
   localparam int unsigned RST_LOW_MIN_US  = 40;
   localparam int unsigned PRES_DELAY_US   = 2;
   localparam int unsigned PRES_WIDTH_US   = 10;
   localparam logic [11:0] RST_LOW_MIN_CYC =
      12'(((RST_LOW_MIN_US * CLK_HZ) + 999_999) / 1_000_000);
   localparam logic [11:0] PRES_DELAY_CYC  =
      12'(((PRES_DELAY_US * CLK_HZ) + 999_999) / 1_000_000);
   localparam logic [11:0] PRES_WIDTH_CYC  =
      12'(((PRES_WIDTH_US * CLK_HZ) + 999_999) / 1_000_000);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic out;
      logic oe_n;
   } od_drive_t;

   typedef enum logic [2:0] {
      ST_WARMUP = 3'b000,
      ST_SENSE  = 3'b001,
      ST_OWN_A  = 3'b010,
      ST_OWN_B  = 3'b011,
      ST_CHARGE = 3'b100,
      ST_PASS   = 3'b101
   } token_state_t;

   typedef enum logic [1:0] {
      PR_IDLE  = 2'b00,
      PR_LOW   = 2'b01,
      PR_WAIT  = 2'b10,
      PR_PULSE = 2'b11
   } pres_state_t;

endpackage

// >>> core/token_pin_control.sv
// Token arbitration, pass-through and charge-gate pin logic of the link bridge
//
// Functional notes
// - Owner pin low for A, high B
// - Owner pin toggles as clock in pass-through
// - Port A answers only while owner low
// - Multi-function pin: charger gate, else GPIO
// - Charger gate pulls low only above 4V
// - Pass-through copies each port onto other
// - Presence pulse after host reset pulse
// - A-only power: charge sense at 1.5ms
// - States on 30kHz tick, timer 10kHz
// - A falling edge restarts timer; expiry hands B
// - High voltage after warm-up: charge, token B
`timescale 1ns/1ps
`default_nettype none
module token_pin_control
   import token_link_pkg::*;
#(
   parameter int unsigned WARMUP_CYCLES    = WARMUP_CYC,
   parameter int unsigned CHG_SENSE_CYCLES = CHG_SENSE_CYC
)
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   input  wire logic                   port_a_line_in,
   input  wire logic                   port_b_line_in,
   input  wire logic                   charge_gate_or_gpio_c_in,
   input  wire logic                   high_voltage_on_a,
   input  wire logic                   powered_from_a_only,
   input  wire logic                   pin_func_gpio_sel,
   input  wire logic                   passthrough_mode,
   input  wire logic                   gpio_c_drive_low,
   output token_link_pkg::od_drive_t   port_a_line_drv,
   output token_link_pkg::od_drive_t   port_b_line_drv,
   output token_link_pkg::od_drive_t   owner_pin_drv,
   output token_link_pkg::od_drive_t   charge_gate_or_gpio_c_drv,
   output var logic                    gpio_c_level,
   output var logic                    charge_active,
   output var logic                    warmup_done
);
   import token_link_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   token_state_t state_reg;
   token_state_t state_next;
   logic [16:0]  warm_cnt_reg;
   logic         hv_early_reg;
   logic [9:0]   osc_cnt_reg;
   logic         osc_tick;
   logic [1:0]   tdiv_reg;
   logic         timer_tick;
   logic [3:0]   timer_reg;
   logic         timer_expired;
   logic         a_prev_reg;
   logic         a_fell_reg;
   logic         token_clk_reg;
   logic         drive_a_reg;
   logic         drive_b_reg;
   logic         pres_a;
   logic         pres_b;
   logic         hv_seen;
   logic         token_a;
   logic         token_b;
   logic         in_pass;

   // ----------------------------------------------------------------
   // Internal oscillator and timer base
   // ----------------------------------------------------------------
   // Oscillator is emulated by dividing the system clock
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         osc_cnt_reg <= 10'h000;
      else if (osc_tick)
         osc_cnt_reg <= 10'h000;
      else
         osc_cnt_reg <= osc_cnt_reg + 10'h001;
   end
   assign osc_tick = (osc_cnt_reg == 10'(OSC_DIV - 1));

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         tdiv_reg <= 2'h0;
      else if (osc_tick)
         tdiv_reg <= (tdiv_reg == 2'(TIMER_DIV - 1)) ? 2'h0 : tdiv_reg + 2'h1;
   end
   assign timer_tick = osc_tick && (tdiv_reg == 2'(TIMER_DIV - 1));

   // ----------------------------------------------------------------
   // Power-up warm-up and early charge sense
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         warm_cnt_reg <= 17'h00000;
      else if (warm_cnt_reg != 17'(WARMUP_CYCLES))
         warm_cnt_reg <= warm_cnt_reg + 17'h00001;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         warmup_done <= 1'b0;
      else
         warmup_done <= (warm_cnt_reg == 17'(WARMUP_CYCLES));
   end

   // Sampling once at 1.5 ms avoids reading the comparator while the
   // parasitic supply is still charging.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         hv_early_reg <= 1'b0;
      else if (powered_from_a_only && (warm_cnt_reg == 17'(CHG_SENSE_CYCLES)))
         hv_early_reg <= high_voltage_on_a;
      else if (osc_tick && (state_reg == ST_SENSE))
         hv_early_reg <= 1'b0;
   end

   // Early sample serves the first sense only; later senses use the live comparator
   assign hv_seen = hv_early_reg || high_voltage_on_a;

   // ----------------------------------------------------------------
   // Port A low timer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         a_prev_reg <= 1'b1;
         a_fell_reg <= 1'b0;
      end else begin
         a_prev_reg <= port_a_line_in;
         a_fell_reg <= a_prev_reg && !port_a_line_in;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         timer_reg <= TIMER_TIMEOUT;
      else if (a_fell_reg || state_reg != ST_OWN_A)
         timer_reg <= TIMER_TIMEOUT;
      else if (timer_tick && timer_reg != 4'h0)
         timer_reg <= timer_reg - 4'h1;
   end
   assign timer_expired = (timer_reg == 4'h0);

   // ----------------------------------------------------------------
   // Token state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_WARMUP: begin
            if (warmup_done)
               state_next = ST_SENSE;
         end
         ST_SENSE: begin
            if (!pin_func_gpio_sel && hv_seen)
               state_next = ST_CHARGE;
            else if (passthrough_mode)
               state_next = ST_PASS;
            else if (port_a_line_in)
               state_next = ST_OWN_A;
            else
               state_next = ST_OWN_B;
         end
         ST_OWN_A: begin
            if (!pin_func_gpio_sel && high_voltage_on_a)
               state_next = ST_CHARGE;
            else if (passthrough_mode)
               state_next = ST_PASS;
            else if (timer_expired && !port_a_line_in)
               state_next = ST_OWN_B;
         end
         ST_OWN_B: begin
            if (port_a_line_in)
               state_next = ST_SENSE;
         end
         ST_CHARGE: begin
            if (pin_func_gpio_sel || !high_voltage_on_a)
               state_next = ST_SENSE;
         end
         ST_PASS: begin
            if (!passthrough_mode)
               state_next = ST_SENSE;
         end
         default: begin
            state_next = ST_SENSE;
         end
      endcase
   end

   // All transitions wait for the oscillator tick
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         state_reg <= ST_WARMUP;
      else if (osc_tick)
         state_reg <= state_next;
   end

   assign token_a = (state_reg == ST_OWN_A);
   assign token_b = (state_reg == ST_OWN_B) || (state_reg == ST_CHARGE);
   assign in_pass = (state_reg == ST_PASS);

   // ----------------------------------------------------------------
   // Owner pin
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         token_clk_reg <= 1'b0;
      else if (in_pass && osc_tick)
         token_clk_reg <= !token_clk_reg;
      else if (!in_pass)
         token_clk_reg <= 1'b0;
   end

   // Released (high) for port B and during warm-up
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         owner_pin_drv <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         owner_pin_drv.out <= 1'b0;
         if (in_pass)
            owner_pin_drv.oe_n <= token_clk_reg;
         else
            owner_pin_drv.oe_n <= !token_a;
      end
   end

   // ----------------------------------------------------------------
   // Pass-through repeaters
   // ----------------------------------------------------------------
   // Each repeater is blocked while the other drives, so a low that we
   // copied cannot be copied back and latch both lines low.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         drive_a_reg <= 1'b0;
         drive_b_reg <= 1'b0;
      end else begin
         drive_b_reg <= in_pass && !port_a_line_in && !drive_a_reg;
         drive_a_reg <= in_pass && !port_b_line_in && !drive_b_reg;
      end
   end

   // ----------------------------------------------------------------
   // Presence responders
   // ----------------------------------------------------------------
   presence_responder u_pres_a (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .line_in  (port_a_line_in),
      .enable   (warmup_done && token_a),
      .pull_low (pres_a)
   );

   presence_responder u_pres_b (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .line_in  (port_b_line_in),
      .enable   (warmup_done && token_b),
      .pull_low (pres_b)
   );

   always_comb begin
      port_a_line_drv.out  = 1'b0;
      port_a_line_drv.oe_n = !(pres_a || drive_a_reg);
      port_b_line_drv.out  = 1'b0;
      port_b_line_drv.oe_n = !(pres_b || drive_b_reg);
   end

   // ----------------------------------------------------------------
   // Multi-function pin
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         charge_gate_or_gpio_c_drv <= '{out: 1'b0, oe_n: 1'b1};
         charge_active             <= 1'b0;
         gpio_c_level              <= 1'b1;
      end else begin
         charge_gate_or_gpio_c_drv.out <= 1'b0;
         charge_active                 <= (state_reg == ST_CHARGE);
         gpio_c_level                  <= charge_gate_or_gpio_c_in;
         if (pin_func_gpio_sel)
            charge_gate_or_gpio_c_drv.oe_n <= !gpio_c_drive_low;
         else
            charge_gate_or_gpio_c_drv.oe_n <= (state_reg != ST_CHARGE);
      end
   end
endmodule
`default_nettype wire

// >>> dv/host_pair.sv
// Two single-wire hosts with pulled-up lines
`timescale 1ns/1ps
`default_nettype none
module host_pair
   import token_link_pkg::*;
(
   input  wire logic                      a_pull,
   input  wire logic                      b_pull,
   input  wire token_link_pkg::od_drive_t dev_a,
   input  wire token_link_pkg::od_drive_t dev_b,
   output var  logic                      a_line,
   output var  logic                      b_line
);
   // Pull-up wins unless the host or the device pulls low
   always_comb a_line = !(a_pull || !dev_a.oe_n);
   always_comb b_line = !(b_pull || !dev_b.oe_n);
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the token pin control
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import token_link_pkg::*;
   logic      clk_sys = 1'b0;
   logic      rst_b = 1'b0;
   logic      a_pull = 1'b0;
   logic      b_pull = 1'b0;
   logic      hv = 1'b0;
   logic      sel = 1'b0;
   logic      pt = 1'b0;
   logic      gpio_low = 1'b0;
   logic      a_only = 1'b0;
   logic      a_oe_n;
   logic      b_oe_n;
   logic      own_oe_n;
   logic      a_line;
   logic      b_line;
   logic      c_pin;
   od_drive_t a_drv;
   od_drive_t b_drv;
   od_drive_t own_drv;
   od_drive_t c_drv;
   logic      c_level;
   logic      chg;
   logic      done;
   int        n_errors = 0;
   int        checks_done = 0;
   initial forever #20 clk_sys = ~clk_sys;
   assign c_pin = c_drv.oe_n | c_drv.out;
   // Plain copies so the wait task can take them by reference
   assign a_oe_n   = a_drv.oe_n;
   assign b_oe_n   = b_drv.oe_n;
   assign own_oe_n = own_drv.oe_n;
   host_pair hosts (.a_pull, .b_pull, .dev_a(a_drv), .dev_b(b_drv), .a_line, .b_line);
   // Short warm-up keeps the run brief
   token_pin_control #(.WARMUP_CYCLES(2000), .CHG_SENSE_CYCLES(600)) uut (
      .clk_sys, .rst_b, .port_a_line_in(a_line), .port_b_line_in(b_line),
      .charge_gate_or_gpio_c_in(c_pin), .high_voltage_on_a(hv), .powered_from_a_only(a_only),
      .pin_func_gpio_sel(sel), .passthrough_mode(pt), .gpio_c_drive_low(gpio_low),
      .port_a_line_drv(a_drv), .port_b_line_drv(b_drv), .owner_pin_drv(own_drv),
      .charge_gate_or_gpio_c_drv(c_drv), .gpio_c_level(c_level), .charge_active(chg),
      .warmup_done(done));
   // -----------------
   // Shared tasks
   // -----------------
   task automatic check(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_n(input string what, input int exp, input int got);
      checks_done++;
      if (got != exp) begin
         n_errors++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wait_for(ref logic sig, input logic val, input int lim, output int n);
      n = 0;
      while (sig !== val && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   // Host reset pulse of 1000 cycles; only the chosen lines are touched
   task automatic host_reset(input logic on_a, input logic on_b);
      if (on_a) a_pull = 1'b1;
      if (on_b) b_pull = 1'b1;
      cycles(1000);
      if (on_a) a_pull = 1'b0;
      if (on_b) b_pull = 1'b0;
   endtask
   task automatic stop_test();
      $display("Checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // -----------------
   // Scenarios
   // -----------------
   task automatic t_warmup();
      int n;
      host_reset(1'b1, 1'b0);
      wait_for(a_oe_n, 1'b0, 300, n);
      check("presence in warm-up", 1'b1, a_drv.oe_n);
      wait_for(done, 1'b1, 2000, n);
      check("warmup_done", 1'b1, done);
   endtask
   task automatic t_presence();
      int n;
      wait_for(own_oe_n, 1'b0, 3000, n);
      check("owner A", 1'b0, own_drv.oe_n);
      check("gate idle", 1'b1, c_drv.oe_n);
      cycles(10);
      host_reset(1'b1, 1'b1);
      wait_for(a_oe_n, 1'b0, 100, n);
      // One more than the delay: the count includes the first high sample edge
      check_n("presence delay A", int'(PRES_DELAY_CYC) + 1, n);
      check("B refused", 1'b1, b_drv.oe_n);
      wait_for(a_oe_n, 1'b1, 300, n);
      check_n("presence width A", int'(PRES_WIDTH_CYC), n);
      cycles(20);
   endtask
   task automatic t_timeout();
      int n;
      a_pull = 1'b1;
      wait_for(own_oe_n, 1'b1, 6000, n);
      check("owner B on timeout", 1'b1, own_drv.oe_n);
      host_reset(1'b0, 1'b1);
      wait_for(b_oe_n, 1'b0, 100, n);
      check_n("presence delay B", int'(PRES_DELAY_CYC) + 1, n);
      cycles(300);
   endtask
   task automatic t_charge();
      int n;
      hv = 1'b1;
      a_pull = 1'b0;
      wait_for(chg, 1'b1, 3000, n);
      check("charge_active", 1'b1, chg);
      check("owner B in charge", 1'b1, own_drv.oe_n);
      check("gate on", 1'b0, c_drv.oe_n);
      cycles(2);
      check("gpio_c_level", 1'b0, c_level);
      pt = 1'b1;
      sel = 1'b1;
      gpio_low = 1'b1;
      cycles(2);
      check("gpio pull", 1'b0, c_drv.oe_n);
      gpio_low = 1'b0;
      cycles(2);
      check("gpio release", 1'b1, c_drv.oe_n);
   endtask
   task automatic t_pass();
      int   toggles;
      logic last;
      toggles = 0;
      cycles(2000);
      last = own_drv.oe_n;
      repeat (2000) begin
         @(negedge clk_sys);
         if (own_drv.oe_n !== last) toggles++;
         last = own_drv.oe_n;
      end
      check("owner clocks", 1'b1, toggles >= 2);
      a_pull = 1'b1;
      cycles(2);
      check("A copied to B", 1'b0, b_drv.oe_n);
      a_pull = 1'b0;
      cycles(2);
      b_pull = 1'b1;
      cycles(2);
      check("B copied to A", 1'b0, a_drv.oe_n);
      b_pull = 1'b0;
      cycles(2);
      hv = 1'b0;
      sel = 1'b0;
      pt = 1'b0;
      cycles(2000);
      check("owner A again", 1'b0, own_drv.oe_n);
      check("charge off", 1'b0, chg);
   endtask
   // Supply from port A only: high voltage is latched once, early in warm-up
   task automatic t_a_only();
      int n;
      a_only = 1'b1;
      a_pull = 1'b0;
      hv = 1'b1;
      rst_b = 1'b0;
      cycles(8);
      rst_b = 1'b1;
      cycles(2);
      check("done after reset", 1'b0, done);
      // Well past the 600-cycle sense point set on the instance
      cycles(1000);
      hv = 1'b0;
      wait_for(chg, 1'b1, 3000, n);
      check("charge from early sense", 1'b1, chg);
      wait_for(own_oe_n, 1'b0, 2500, n);
      check("owner A after early sense", 1'b0, own_oe_n);
   endtask
   initial begin
      #(60000 * 40);
      n_errors++;
      $display("Error watchdog expected finish seen hang");
      stop_test();
   end
   initial begin
      cycles(8);
      check("owner reset", 1'b1, own_drv.oe_n);
      check("gpio level reset", 1'b1, c_level);
      check("done reset", 1'b0, done);
      rst_b = 1'b1;
      t_warmup();
      t_presence();
      t_timeout();
      t_charge();
      t_pass();
      t_a_only();
      stop_test();
   end
endmodule
bind token_pin_control token_pin_sva chk (.clk_sys, .rst_b, .port_a_line_in, .port_b_line_in,
   .pin_func_gpio_sel, .passthrough_mode, .gpio_c_drive_low, .port_a_line_drv,
   .port_b_line_drv, .owner_pin_drv, .charge_gate_or_gpio_c_drv, .charge_active, .warmup_done);
`default_nettype wire

// >>> dv/token_pin_sva.sv
// Concurrent checks on the token pin control ports
`timescale 1ns/1ps
`default_nettype none
module token_pin_sva
   import token_link_pkg::*;
(
   input wire logic                      clk_sys,
   input wire logic                      rst_b,
   input wire logic                      port_a_line_in,
   input wire logic                      port_b_line_in,
   input wire logic                      pin_func_gpio_sel,
   input wire logic                      passthrough_mode,
   input wire logic                      gpio_c_drive_low,
   input wire token_link_pkg::od_drive_t port_a_line_drv,
   input wire token_link_pkg::od_drive_t port_b_line_drv,
   input wire token_link_pkg::od_drive_t owner_pin_drv,
   input wire token_link_pkg::od_drive_t charge_gate_or_gpio_c_drv,
   input wire logic                      charge_active,
   input wire logic                      warmup_done
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // -----------------
   // Presence width counter and port checks
   // -----------------
   logic [8:0] low_cnt_reg;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt_reg <= 9'h000;
      end else if (port_a_line_drv.oe_n) begin
         low_cnt_reg <= 9'h000;
      end else begin
         low_cnt_reg <= low_cnt_reg + 9'h001;
      end
   end
   a_warmup_quiet: assert property (
      !warmup_done |-> port_a_line_drv.oe_n && port_b_line_drv.oe_n && owner_pin_drv.oe_n)
      else $error("port active during warm-up");
   a_done_stays: assert property (
      warmup_done |=> warmup_done) else $error("warm-up done dropped");
   a_a_needs_owner: assert property (
      $fell(port_a_line_drv.oe_n) && !passthrough_mode |-> !owner_pin_drv.oe_n)
      else $error("port A answered without token");
   a_b_needs_token: assert property (
      $fell(port_b_line_drv.oe_n) && !passthrough_mode |-> owner_pin_drv.oe_n)
      else $error("port B answered while owner low");
   a_pres_width: assert property (
      $rose(port_a_line_drv.oe_n) && !passthrough_mode |-> low_cnt_reg == 9'h0FA)
      else $error("presence width wrong");
   a_charge_gate: assert property (
      !$past(pin_func_gpio_sel) |-> charge_gate_or_gpio_c_drv.oe_n == !charge_active)
      else $error("charge gate not tied to charge state");
   a_gpio_follow: assert property (
      $past(pin_func_gpio_sel) |-> charge_gate_or_gpio_c_drv.oe_n == !$past(gpio_c_drive_low))
      else $error("gpio drive not followed");
   a_pass_ab: assert property (
      passthrough_mode && !port_a_line_in && port_a_line_drv.oe_n |=> !port_b_line_drv.oe_n)
      else $error("A low not copied to B");
   a_pass_ba: assert property (
      passthrough_mode && !port_b_line_in && port_b_line_drv.oe_n |=> !port_a_line_drv.oe_n)
      else $error("B low not copied to A");
endmodule
`default_nettype wire
